// ### core/cftte_unit.v
// Fault, trap and trace exception control of the integer core
`timescale 1ns/1ps
`default_nettype none
`include "cftte_defines.vh"
module cftte_unit (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        instr_start,
    input  wire        instr_done,
    input  wire        instr_suspend,
    input  wire [15:0] opcode,
    input  wire        opcode_invalid,
    input  wire        ctrl_move_bad_reg,
    input  wire        fp_unimpl,
    input  wire        privileged_op,
    input  wire        change_of_flow,
    input  wire        stop_op,
    input  wire        divide_op,
    input  wire        divisor_zero,
    input  wire        check_fail,
    input  wire        call_taken,
    input  wire        num_call,
    input  wire [3:0]  num_call_n,
    input  wire        prefetch_req,
    input  wire [31:0] prefetch_addr,
    input  wire        bkpt_ack_end,
    input  wire        bus_fault_active,
    input  wire        reset_active,
    input  wire        frame_done,
    input  wire [15:0] status_register,
    input  wire [31:0] program_counter,
    input  wire [31:0] next_pc,
    input  wire [31:0] operand_effective_address,
    output reg         prefetch_go,
    output reg         exc_req,
    output reg  [7:0]  exc_vector,
    output reg  [9:0]  exc_vector_offset,
    output reg  [3:0]  exc_format,
    output reg  [15:0] exc_sr_copy,
    output reg  [15:0] sr_new,
    output reg  [31:0] exc_stacked_pc,
    output reg  [31:0] exc_fault_pc,
    output reg         exc_fault_pc_valid,
    output reg  [31:0] exc_fault_addr,
    output reg         exc_fault_addr_valid,
    output reg         stop_enter,
    output reg  [3:0]  processor_state_outputs,
    output reg         halted
);
    // ==========================================
    // State
    localparam ST_RUN  = 2'h0;
    localparam ST_EXC  = 2'h1;
    localparam ST_HALT = 2'h3;
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [1:0]  trace_mode_reg;
    reg         trace_owed_reg;
    reg         trace_due_reg;
    reg         ae_pend_reg;
    reg  [31:0] ae_addr_reg;
    reg  [31:0] ae_pc_reg;
    reg         in_fault_proc_reg;
    wire        trace_select_high = status_register[`CFTTE_SR_T1_BIT];
    wire        trace_select_low  = status_register[`CFTTE_SR_T0_BIT];
    wire        user_mode = ~status_register[`CFTTE_SR_S_BIT];
    wire        odd_fetch = prefetch_req & prefetch_addr[0];

    // ==========================================
    // Exception selection
    reg         sel;
    reg  [7:0]  vec;
    reg  [3:0]  fmt;
    reg  [31:0] spc;
    reg  [31:0] fpc;
    reg         fpc_v;
    reg  [31:0] fad;
    reg         fad_v;
    reg         is_ae;
    reg         is_trace;
    wire        bad_op = instr_start & (opcode_invalid | ctrl_move_bad_reg);
    wire        line_a = instr_start & (opcode[15:12] == `CFTTE_OP_LINE_A);
    wire        line_f = instr_start & (opcode[15:12] == `CFTTE_OP_LINE_F) & (opcode_invalid | fp_unimpl);
    wire        priv = instr_start & privileged_op & user_mode;
    wire        traced = (instr_done & ~instr_suspend & trace_owed_reg) | trace_due_reg;
    wire        forced = instr_done & ~instr_suspend &
                         ((divide_op & divisor_zero) | check_fail | call_taken | num_call);
    always @* begin
        sel = 1'b0;
        vec = 8'h00;
        fmt = `CFTTE_FMT_NORMAL;
        spc = program_counter;
        fpc = program_counter;
        fpc_v = 1'b0;
        fad = 32'h0000_0000;
        fad_v = 1'b0;
        is_ae = 1'b0;
        is_trace = 1'b0;
        if (bkpt_ack_end) begin
            sel = 1'b1; // RL12
            vec = `CFTTE_VEC_ILLEGAL;
        end else if (line_a) begin
            sel = 1'b1; // RL13 RL15
            vec = `CFTTE_VEC_LINE_A;
        end else if (line_f & fp_unimpl & ~opcode_invalid) begin
            sel = 1'b1; // RL16
            vec = `CFTTE_VEC_LINE_F;
            fmt = `CFTTE_FMT_FLOAT;
            spc = next_pc;
            fad = operand_effective_address;
            fad_v = 1'b1;
            fpc_v = 1'b1;
        end else if (line_f) begin
            sel = 1'b1; // RL14 RL15
            vec = `CFTTE_VEC_LINE_F;
        end else if (bad_op) begin
            sel = 1'b1; // RL11 RL15
            vec = `CFTTE_VEC_ILLEGAL;
        end else if (priv) begin
            sel = 1'b1; // RL17
            vec = `CFTTE_VEC_PRIV;
        end else if (forced) begin
            sel = 1'b1; // RL6 RL9 RL22
            spc = next_pc;
            fmt = `CFTTE_FMT_FMT2;
            fpc_v = ~num_call; // RL10
            if (num_call)
                vec = `CFTTE_VEC_NUM_BASE + {4'h0, num_call_n}; // RL8
            else if (divide_op & divisor_zero)
                vec = `CFTTE_VEC_DIV_ZERO; // RL7
            else if (check_fail)
                vec = `CFTTE_VEC_CHECK;
            else
                vec = `CFTTE_VEC_CALL;
            if (num_call)
                fmt = `CFTTE_FMT_NORMAL;
        end else if (traced) begin
            sel = 1'b1; // RL24 RL22
            is_trace = 1'b1;
            vec = `CFTTE_VEC_TRACE;
            spc = next_pc;
        end else if (ae_pend_reg & ~instr_start) begin
            sel = 1'b1; // RL2 RL3
            is_ae = 1'b1;
            vec = `CFTTE_VEC_ADDR_ERR;
            fmt = `CFTTE_FMT_ADDR;
            fpc = ae_pc_reg;
            fpc_v = 1'b1;
            fad = {ae_addr_reg[31:1], 1'b0};
            fad_v = 1'b1;
        end
    end

    // ==========================================
    // Sequencing
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (sel)
                    state_next = ST_EXC;
            end
            ST_EXC: begin
                if (frame_done)
                    state_next = ST_RUN;
            end
            ST_HALT: state_next = ST_HALT; // RL5
            default: state_next = ST_RUN;
        endcase
        if (odd_fetch & (bus_fault_active | reset_active | in_fault_proc_reg))
            state_next = ST_HALT; // RL4
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= ST_RUN;
            trace_mode_reg <= `CFTTE_TRACE_NONE;
            trace_owed_reg <= 1'b0;
            trace_due_reg <= 1'b0;
            ae_pend_reg <= 1'b0;
            ae_addr_reg <= 32'h0000_0000;
            ae_pc_reg <= 32'h0000_0000;
            in_fault_proc_reg <= 1'b0;
            prefetch_go <= 1'b0;
            exc_req <= 1'b0;
            exc_vector <= 8'h00;
            exc_vector_offset <= 10'h000;
            exc_format <= `CFTTE_FMT_NORMAL;
            exc_sr_copy <= 16'h0000;
            sr_new <= 16'h0000;
            exc_stacked_pc <= 32'h0000_0000;
            exc_fault_pc <= 32'h0000_0000;
            exc_fault_pc_valid <= 1'b0;
            exc_fault_addr <= 32'h0000_0000;
            exc_fault_addr_valid <= 1'b0;
            stop_enter <= 1'b0;
            processor_state_outputs <= `CFTTE_PST_NORMAL;
            halted <= 1'b0;
        end else begin
            state_reg <= state_next;
            exc_req <= 1'b0;
            stop_enter <= 1'b0;
            prefetch_go <= prefetch_req & ~prefetch_addr[0] & (state_next != ST_HALT); // RL1
            if (state_next == ST_HALT) begin
                halted <= 1'b1; // RL5
                processor_state_outputs <= `CFTTE_PST_HALT;
                exc_req <= 1'b0;
            end else begin
                if (state_reg == ST_EXC & frame_done)
                    in_fault_proc_reg <= 1'b0;
                if (odd_fetch & ~ae_pend_reg) begin
                    ae_pend_reg <= 1'b1; // RL1
                    ae_addr_reg <= prefetch_addr;
                    ae_pc_reg <= program_counter;
                end
                if (instr_start) begin
                    trace_mode_reg <= {trace_select_high, trace_select_low}; // RL19
                    trace_owed_reg <= ({trace_select_high, trace_select_low} == `CFTTE_TRACE_ALL) |
                        (({trace_select_high, trace_select_low} == `CFTTE_TRACE_FLOW) &
                         (change_of_flow | stop_op)); // RL18 RL20
                end
                if (instr_done & ~instr_suspend & trace_owed_reg)
                    trace_due_reg <= 1'b1; // RL22
                if (instr_done & ~instr_suspend & stop_op &
                    ~(trace_owed_reg & trace_mode_reg == `CFTTE_TRACE_ALL))
                    stop_enter <= ~trace_owed_reg; // RL25
                if (sel & state_reg == ST_RUN) begin
                    exc_req <= 1'b1;
                    exc_vector <= vec;
                    exc_vector_offset <= {vec, 2'b00}; // RL26
                    exc_format <= fmt;
                    exc_sr_copy <= status_register; // RL9
                    sr_new <= (status_register | (16'h0001 << `CFTTE_SR_S_BIT)) &
                              ~((16'h0001 << `CFTTE_SR_T1_BIT) | (16'h0001 << `CFTTE_SR_T0_BIT));
                    exc_stacked_pc <= spc;
                    exc_fault_pc <= fpc;
                    exc_fault_pc_valid <= fpc_v;
                    exc_fault_addr <= fad;
                    exc_fault_addr_valid <= fad_v;
                    if (is_ae) begin
                        ae_pend_reg <= 1'b0;
                        in_fault_proc_reg <= 1'b1;
                    end
                    if (is_trace | bad_op | line_a | line_f)
                        trace_owed_reg <= 1'b0; // RL23
                    if (is_trace)
                        trace_due_reg <= 1'b0; // RL22
                end
                if (instr_suspend)
                    trace_owed_reg <= trace_owed_reg; // RL21
            end
        end
    end
endmodule
`default_nettype wire

// ### core/cftte_defines.vh
// Constants for the fault, trap and trace exception unit
// Function
// RL1 - Odd prefetch: no bus cycle, error after completion
// RL2 - Address error uses vector 3, bit0 cleared
// RL3 - New exception from completion served before address error
// RL4 - Address error during fault processing: double fault
// RL5 - Double fault halts, state 0111, reset only
// RL6 - Zero divisor on divide traps
// RL7 - Vectors 5 divide, 6 checks, 7 calls
// RL8 - Numbered call always traps, vector 32 plus n
// RL9 - Trap: copy status, supervisor, clear trace, stack
// RL10 - Non-numbered traps also save faulting address
// RL11 - Invalid opcode or bad control move: vector 4
// RL12 - Breakpoint acknowledge end gives illegal instruction
// RL13 - Opcode line A gives vector 10
// RL14 - Illegal line F opcode gives vector 11
// RL15 - Bad opcodes not executed, stack own address
// RL16 - Float opcode: effective address, long frame
// RL17 - Privileged op in user mode: vector 8
// RL18 - Trace bits select none, flow, all, reserved
// RL19 - Trace bits sampled at instruction start
// RL20 - Flow tracing covers branches, traps, status writes
// RL21 - Suspended traced instruction traces after completion
// RL22 - Forced exception, then trace, then interrupt
// RL23 - Bad opcodes never traced
// RL24 - Trace uses vector 9, next address stacked
// RL25 - Traced stop loads status, traces, never stops
// RL26 - Vector offset is vector number times four
`ifndef CFTTE_DEFINES_VH
`define CFTTE_DEFINES_VH
`define CFTTE_VEC_ADDR_ERR   8'h03
`define CFTTE_VEC_ILLEGAL    8'h04
`define CFTTE_VEC_DIV_ZERO   8'h05
`define CFTTE_VEC_CHECK      8'h06
`define CFTTE_VEC_CALL       8'h07
`define CFTTE_VEC_PRIV       8'h08
`define CFTTE_VEC_TRACE      8'h09
`define CFTTE_VEC_LINE_A     8'h0a
`define CFTTE_VEC_LINE_F     8'h0b
`define CFTTE_VEC_NUM_BASE   8'h20
`define CFTTE_OP_LINE_A      4'ha
`define CFTTE_OP_LINE_F      4'hf
`define CFTTE_PST_HALT       4'h7
`define CFTTE_PST_NORMAL     4'h0
`define CFTTE_TRACE_NONE     2'h0
`define CFTTE_TRACE_FLOW     2'h1
`define CFTTE_TRACE_ALL      2'h2
`define CFTTE_SR_S_BIT       13
`define CFTTE_SR_T0_BIT      14
`define CFTTE_SR_T1_BIT      15
`define CFTTE_FMT_NORMAL     4'h0
`define CFTTE_FMT_ADDR       4'h2
`define CFTTE_FMT_FLOAT      4'h4
`define CFTTE_FMT_FMT2       4'h2
`endif

// ### verification/cftte_unit_sva.sv
// Port checker for the exception unit
`timescale 1ns/1ps
`default_nettype none
module cftte_unit_sva (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        instr_done,
    input wire logic        divide_op,
    input wire logic        divisor_zero,
    input wire logic        num_call,
    input wire logic [3:0]  num_call_n,
    input wire logic        prefetch_req,
    input wire logic [31:0] prefetch_addr,
    input wire logic        prefetch_go,
    input wire logic        exc_req,
    input wire logic [7:0]  exc_vector,
    input wire logic [9:0]  exc_vector_offset,
    input wire logic [15:0] sr_new,
    input wire logic        exc_fault_pc_valid,
    input wire logic [31:0] exc_fault_addr,
    input wire logic        exc_fault_addr_valid,
    input wire logic [3:0]  processor_state_outputs,
    input wire logic        halted
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ==========
    // Causes and answers
    sequence div_zero;
        instr_done && divide_op && divisor_zero;
    endsequence
    sequence odd_fetch;
        prefetch_req && prefetch_addr[0];
    endsequence
    chk_div_vector: assert property (div_zero |=> exc_req && exc_vector == 8'h05)
        else $error("divide trap vector wrong");
    chk_offset_four: assert property (exc_req |-> exc_vector_offset == {exc_vector, 2'b00})
        else $error("vector offset wrong");
    chk_sr_super: assert property (exc_req |-> sr_new[15:13] == 3'b001)
        else $error("new status wrong");
    chk_num_call: assert property (instr_done && num_call |=> exc_vector == 8'h20 + num_call_n)
        else $error("numbered call vector wrong");
    chk_num_nopc: assert property (instr_done && num_call |=> !exc_fault_pc_valid)
        else $error("numbered call saved fault pc");
    chk_odd_nofetch: assert property (odd_fetch |=> !prefetch_go)
        else $error("odd prefetch issued");
    chk_addr_even: assert property (exc_fault_addr_valid |-> !exc_fault_addr[0])
        else $error("fault address bit0 set");
    chk_halt_state: assert property (halted |-> processor_state_outputs == 4'h7)
        else $error("halt state wrong");
    chk_halt_holds: assert property (halted |=> halted)
        else $error("halt left without reset");
endmodule
bind cftte_unit cftte_unit_sva chk (.*);
`default_nettype wire

// ### verification/cftte_pipe_model.sv
// Pipeline side model that finishes exception frames
`timescale 1ns/1ps
`default_nettype none
module cftte_pipe_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic exc_req,
    output logic     frame_done
);
    // ==========
    // Frame stacking delay
    logic [3:0] cnt_reg;
    always @(posedge sys_clk) begin
        frame_done <= 1'b0;
        if (rst)
            cnt_reg <= 4'h0;
        else if (exc_req)
            cnt_reg <= slow ? 4'h8 : 4'h1;
        else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
            frame_done <= (cnt_reg == 4'h1);
        end
    end
endmodule
`default_nettype wire

// ### verification/cpu_fault_trap_trace_exceptions_test.sv
// Self-checking bench of the exception unit
`timescale 1ns/1ps
`default_nettype none
module cpu_fault_trap_trace_exceptions_test;
    logic sys_clk = 0, rst = 1, slow = 0, instr_start = 0, instr_done = 0, instr_suspend = 0, fp_unimpl = 0;
    logic opcode_invalid = 0, ctrl_move_bad_reg = 0, privileged_op = 0, change_of_flow = 0, stop_op = 0;
    logic divide_op = 0, divisor_zero = 0, check_fail = 0, call_taken = 0, num_call = 0, prefetch_req = 0;
    logic bkpt_ack_end = 0, bus_fault_active = 0, reset_active = 0;
    logic [3:0] num_call_n = 4'hf;
    logic [15:0] opcode = 16'h4e71, status_register = 16'h2000;
    logic [31:0] prefetch_addr = 32'h3001, program_counter = 32'h1000, next_pc = 32'h1004;
    logic [31:0] operand_effective_address = 32'h2000;
    wire prefetch_go, exc_req, exc_fault_pc_valid, exc_fault_addr_valid, stop_enter, halted, frame_done;
    wire [7:0] exc_vector;
    wire [9:0] exc_vector_offset;
    wire [3:0] exc_format, processor_state_outputs;
    wire [15:0] exc_sr_copy, sr_new;
    wire [31:0] exc_stacked_pc, exc_fault_pc, exc_fault_addr;
    int err_total = 0, compares = 0, exc_count = 0, stop_count = 0, i, k, n;
    cftte_unit dut (.*);
    cftte_pipe_model model (.*);
    initial forever #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) exc_count <= exc_count + (exc_req === 1'b1);
    always @(posedge sys_clk) stop_count <= stop_count + (stop_enter === 1'b1);
    // ==========
    // Shared tasks
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task tally_and_finish;
        if (err_total == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task tick;
        @(posedge sys_clk);
        {instr_start, instr_done, opcode_invalid, ctrl_move_bad_reg, privileged_op, change_of_flow} <= 6'h00;
        {divide_op, divisor_zero, check_fail, call_taken, num_call, prefetch_req, bkpt_ack_end} <= 7'h00;
        {fp_unimpl, stop_op} <= 2'h0;
        #1;
    endtask
    task expect_exc(input logic [7:0] vec);
        tick();
        for (i = 0; i < 8 && exc_req !== 1'b1; i++)
            tick();
        check("exc_req", exc_req, 1'b1);
        check("exc_vector", exc_vector, vec);
        for (i = 0; i < 12 && frame_done !== 1'b1; i++)
            tick();
        check("frame_done", frame_done, 1'b1);
        if (frame_done !== 1'b1)
            tally_and_finish();
        tick();
    endtask
    task begin_op(input logic [15:0] sr, input logic flow);
        @(posedge sys_clk);
        {status_register, instr_start, change_of_flow} <= {sr, 1'b1, flow};
        tick();
        @(posedge sys_clk);
    endtask
    // ==========
    // Scenarios
    task trap_vectors;
        for (k = 0; k < 3; k++) begin
            @(posedge sys_clk);
            {divide_op, divisor_zero, check_fail, call_taken, instr_done} <= {k == 0, k == 0, k == 1, k == 2, 1'b1};
            expect_exc(8'h05 + k);
            check("stacked pc", exc_stacked_pc, next_pc);
            check("fault pc", exc_fault_pc, program_counter);
            check("trap format", exc_format, 4'h2);
        end
        @(posedge sys_clk);
        {num_call, instr_done, slow} <= 3'h7;
        expect_exc(8'h2f);
        check("call format", exc_format, 4'h0);
    endtask
    task bad_opcodes;
        for (k = 0; k < 5; k++) begin
            @(posedge sys_clk);
            opcode <= k == 0 ? 16'ha123 : k == 1 ? 16'hf123 : k == 4 ? 16'h4e72 : 16'h4e7b;
            {status_register[13], opcode_invalid, ctrl_move_bad_reg, privileged_op, instr_start}
                <= {k != 4, k == 1 || k == 2, k == 3, k == 4, 1'b1};
            expect_exc(k == 0 ? 8'h0a : k == 1 ? 8'h0b : k == 4 ? 8'h08 : 8'h04);
            check("stacked pc", exc_stacked_pc, program_counter);
            check("sr copy", exc_sr_copy, status_register);
        end
        @(posedge sys_clk);
        bkpt_ack_end <= 1'b1;
        expect_exc(8'h04);
        @(posedge sys_clk);
        {opcode, fp_unimpl, instr_start} <= {16'hf200, 2'h3};
        expect_exc(8'h0b);
        check("float format", exc_format, 4'h4);
        check("float pc", exc_stacked_pc, next_pc);
        check("float ea", exc_fault_addr, operand_effective_address);
        check("float fault pc", exc_fault_pc, program_counter);
    endtask
    task trace_modes;
        begin_op(16'ha000, 1'b0);
        {status_register, instr_done} <= {16'h2000, 1'b1};
        expect_exc(8'h09);
        check("trace pc", exc_stacked_pc, next_pc);
        check("trace sr copy", exc_sr_copy, 16'h2000);
        begin_op(16'h6000, 1'b0);
        n = exc_count;
        instr_done <= 1'b1;
        repeat (4) tick();
        check("exc count", exc_count, n);
        begin_op(16'h6000, 1'b1);
        instr_done <= 1'b1;
        expect_exc(8'h09);
        begin_op(16'ha000, 1'b0);
        {divide_op, divisor_zero, instr_done} <= 3'h7;
        expect_exc(8'h05);
        expect_exc(8'h09);
        begin_op(16'ha000, 1'b0);
        n = exc_count;
        {instr_suspend, instr_done} <= 2'h3;
        repeat (3) tick();
        check("exc count", exc_count, n);
        @(posedge sys_clk);
        {instr_suspend, instr_done} <= 2'h1;
        expect_exc(8'h09);
        @(posedge sys_clk);
        n = stop_count;
        {status_register, stop_op, instr_done} <= {16'h2000, 2'h3};
        repeat (2) tick();
        check("stop count", stop_count, n + 1);
        begin_op(16'ha000, 1'b0);
        n = stop_count;
        {stop_op, instr_done} <= 2'h3;
        expect_exc(8'h09);
        check("stop count", stop_count, n);
        @(posedge sys_clk);
        {status_register, opcode, instr_start} <= {16'ha000, 16'ha123, 1'b1};
        expect_exc(8'h0a);
        n = exc_count;
        @(posedge sys_clk);
        instr_done <= 1'b1;
        repeat (4) tick();
        check("exc count", exc_count, n);
    endtask
    task odd_prefetch;
        @(posedge sys_clk);
        {status_register, prefetch_req, slow} <= {16'h2000, 1'b1, 1'b0};
        expect_exc(8'h03);
        check("fault addr", exc_fault_addr, 32'h3000);
        check("ae format", exc_format, 4'h2);
        check("ae fault pc", exc_fault_pc, program_counter);
        @(posedge sys_clk);
        {prefetch_req, divide_op, divisor_zero, instr_done} <= 4'hf;
        expect_exc(8'h05);
        expect_exc(8'h03);
        @(posedge sys_clk);
        {bus_fault_active, prefetch_req} <= 2'h3;
        for (i = 0; i < 8 && halted !== 1'b1; i++)
            tick();
        check("pst", processor_state_outputs, 4'h7);
        @(posedge sys_clk);
        {rst, bus_fault_active} <= 2'h2;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        tick();
        check("halted", halted, 1'b0);
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        trap_vectors();
        bad_opcodes();
        trace_modes();
        odd_prefetch();
        tally_and_finish();
    end
endmodule
`default_nettype wire
